//--- logic/icm_pkg.sv
// Shared constants, register map and state codes of the I2C master engine
package icm_pkg;
  // Core clock and bus timing
  localparam int CLK_NS = 50;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS / CLK_NS) < 1 ? 1 : SPIKE_NS / CLK_NS;
  localparam int STD_PERIOD_NS = 10000;
  localparam int FAST_PERIOD_NS = 2500;
  localparam int QTR_STD_CYC = (STD_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam int QTR_FAST_CYC = (FAST_PERIOD_NS + 4 * CLK_NS - 1)
                                / (4 * CLK_NS);
  // Register byte addresses
  localparam logic [7:0] ADDR_CON = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_ESTATE = 8'h0C;
  localparam logic [7:0] ADDR_SPIKE = 8'h10;
  localparam logic [7:0] ADDR_ABRT = 8'h14;
  localparam logic [7:0] ADDR_RAW = 8'h18;
  localparam logic [7:0] ADDR_BCLR = 8'h1C;
  // Field positions
  localparam int CMD_W = 10;
  localparam int CMD_RNW_BIT = 8;
  localparam int CMD_STOP_BIT = 9;
  localparam int EN_BIT = 0;
  localparam int ABORT_BIT = 1;
  localparam int CON_MASTER_BIT = 0;
  localparam int CON_SPEED_LSB = 1;
  localparam int RAW_TXAB_BIT = 6;
  localparam int ABRT_USER_BIT = 0;
  localparam int RX_VALID_BIT = 8;
  localparam int BCLR_GO_BIT = 0;
  localparam int BCLR_OK_BIT = 1;
  localparam int BCLR_FAIL_BIT = 2;
  // Encodings and reset values
  localparam logic [1:0] SPEED_STD = 2'h1;
  localparam logic [1:0] SPEED_FAST = 2'h2;
  localparam logic [2:0] CON_RST = 3'h5;
  localparam logic [7:0] SPK_RST = 8'(SPIKE_CYC);
  localparam logic [3:0] CLR_LAST = 4'h8;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_START = 7'h02,
    ST_BIT   = 7'h04,
    ST_ACK   = 7'h08,
    ST_HOLD  = 7'h10,
    ST_STOP  = 7'h20,
    ST_CLR   = 7'h40
  } icm_state_e;
endpackage

//--- logic/icm_strm_if.sv
// Valid/ready word channel between the engine and its command buffer
`timescale 1ns/1ps
interface icm_strm_if #(parameter int W = 10);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- logic/icm_buf2.sv
// Small command buffer with flush and back-pressure
`timescale 1ns/1ps
module icm_buf2 import icm_pkg::*; #(
  parameter int W = CMD_W,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  // Channels
  icm_strm_if.snk in_s,
  icm_strm_if.src out_s
);
  localparam int PW = DEPTH > 1 ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } icm_buf_s;
  icm_buf_s r, next_r;
  logic push, pop;

  assign in_s.ready = (r.cnt != CW'(DEPTH));
  assign out_s.valid = (r.cnt != '0);
  assign out_s.data = r.mem[r.rp];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_comb begin
    next_r = r;
    if (flush) begin
      // Flush wins over a push in the same cycle
      next_r.wp = '0;
      next_r.rp = '0;
      next_r.cnt = '0;
    end else begin
      if (push) begin
        next_r.mem[r.wp] = in_s.data;
        next_r.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : PW'(r.wp + 1'b1);
      end
      if (pop) begin
        next_r.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : PW'(r.rp + 1'b1);
      end
      next_r.cnt = CW'(r.cnt + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // icm_buf2

//--- logic/icm_spike_filt.sv
// Two-flop synchroniser followed by a programmable spike filter
`timescale 1ns/1ps
module icm_spike_filt (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Line and setting
  input wire logic pin,
  input wire logic [7:0] limit,
  // Filtered level
  output logic filt
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic run;
    logic out;
    logic [7:0] cnt;
  } icm_filt_s;
  icm_filt_s r, next_r;
  logic chg;

  assign chg = (r.s2 != r.prev);
  assign filt = r.out;

  always_comb begin
    next_r = r;
    next_r.s1 = pin;
    next_r.s2 = r.s1;
    next_r.prev = r.s2;
    // Same path for both directions of a change
    if (chg) begin
      // A second change cancels the run without updating
      next_r.run = !r.run;
      next_r.cnt = '0;
    end else if (r.run) begin
      if ({1'b0, r.cnt} + 9'h001 >= {1'b0, limit}) begin
        next_r.out = r.s2;
        next_r.run = 1'b0;
        next_r.cnt = '0;
      end else begin
        next_r.cnt = r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, run: 1'b0, out: 1'b1,
             cnt: 8'h00};
    end else begin
      r <= next_r;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  filt_update_a: assert property ($changed(r.out) |-> $past(r.run))
    else $error("filtered level moved without a running count");
  filt_cancel_a: assert property (r.run && chg |=> !r.run && $stable(r.out))
    else $error("second change did not cancel the count");
endmodule // icm_spike_filt

//--- logic/icm_master.sv
// I2C master command engine with abort, spike filters and bus clear
// What this block does
// - Write command: data in bits 7:0, bit 8 zero.
// - Read command: bit 8 one, low byte ignored; mixing freely allowed.
// - While enabled, keep starting transfers while commands wait, in order.
// - Command with stop flag ends its transfer with a STOP.
// - No stop flag and empty queue: hold SCL low until next command.
// - Enabled flag in bit 0 of enable state reads one until shut down.
// - Disable without stop flag: stay active holding SCL low until command.
// - Abort issues STOP then flushes the command queue.
// - Abort acts only in master operation.
// - Finished abort sets transmit-abort event and user abort cause.
// - Per-line counter starts on change; stable to limit updates level.
// - Change before limit stops counter, level kept.
// - Two-flop synchroniser ahead of each filter, independent of limit.
// - Spike limit is 8 bits, read/write, written only while disabled.
// - Spike limit written below one stores one.
// - Filtering identical for rising and falling changes.
// - Speed field bits 2:1 value 2'h2 selects fast mode.
// - SDA stuck low: up to nine SCL pulses, SDA released, check each.
// - Recovered: STOP; not recovered after ninth: left to reset.
// - While disabled the command and receive buffers stay cleared.
// - Speed field written only while disabled.
`timescale 1ns/1ps
module icm_master import icm_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // I2C lines, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  typedef struct packed {
    icm_state_e st;
    logic [1:0] ph;
    logic [5:0] div;
    logic [3:0] bcnt;
    logic [CMD_W-1:0] cmd;
    logic [7:0] sh;
    logic scl_lo;
    logic sda_lo;
    logic en;
    logic abort;
    logic aborting;
    logic master;
    logic [1:0] speed;
    logic [7:0] spk;
    logic [7:0] rx;
    logic rx_v;
    logic ucause;
    logic txab;
    logic clr_go;
    logic clr_ok;
    logic clr_fail;
    logic [31:0] rdata;
  } icm_regs_s;
  icm_regs_s r, next_r;

  icm_strm_if #(.W(CMD_W)) win ();
  icm_strm_if #(.W(CMD_W)) wout ();

  logic en_flag, tick, flush, pop, abort_ok;
  logic cmd_wr, acc, hit, scl_f, sda_f;
  logic [1:0] line_raw, line_filt;

  assign line_raw = {sda_in, scl_in};
  assign scl_f = line_filt[0];
  assign sda_f = line_filt[1];

  for (genvar i = 0; i < 2; i++) begin : g_filt
    icm_spike_filt u_filt (
      .clk(mclk),
      .reset_n(reset_n),
      .pin(line_raw[i]),
      .limit(r.spk),
      .filt(line_filt[i])
    );
  end

  icm_buf2 #(.W(CMD_W), .DEPTH(2)) u_buf (
    .clk(mclk),
    .reset_n(reset_n),
    .flush(flush),
    .in_s(win.snk),
    .out_s(wout.src)
  );

  // Enabled until the engine has reached idle
  assign en_flag = r.en | (r.st != ST_IDLE);
  assign tick = (r.div == 6'h00);
  assign abort_ok = r.abort & r.master;
  assign hit = (paddr == ADDR_CON) | (paddr == ADDR_CMD)
             | (paddr == ADDR_ENABLE) | (paddr == ADDR_ESTATE)
             | (paddr == ADDR_SPIKE) | (paddr == ADDR_ABRT)
             | (paddr == ADDR_RAW) | (paddr == ADDR_BCLR);
  // A full buffer stalls the command write, so no word is lost
  assign cmd_wr = psel & penable & pwrite & (paddr == ADDR_CMD);
  assign win.valid = cmd_wr;
  assign win.data = pwdata[CMD_W-1:0];
  assign wout.ready = pop;
  assign pready = !(cmd_wr && !win.ready);
  assign pslverr = psel & penable & !hit;
  assign acc = psel & penable & pready & hit;
  assign prdata = r.rdata;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = r.scl_lo;
  assign sda_oe = r.sda_lo;

  always_comb begin
    next_r = r;
    pop = 1'b0;
    // Queue cleared while disabled
    flush = !en_flag;
    if (!en_flag) begin
      next_r.rx_v = 1'b0;
    end
    // Read data is captured in the setup phase
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_CON: next_r.rdata = {29'h0, r.speed, r.master};
        ADDR_CMD: next_r.rdata = {23'h0, r.rx_v, r.rx};
        ADDR_ENABLE: next_r.rdata = {30'h0, r.abort, r.en};
        ADDR_ESTATE: next_r.rdata = {31'h0, en_flag};
        ADDR_SPIKE: next_r.rdata = {24'h0, r.spk};
        ADDR_ABRT: next_r.rdata = {31'h0, r.ucause};
        ADDR_RAW: next_r.rdata = {25'h0, r.txab, 6'h00};
        ADDR_BCLR: next_r.rdata = {29'h0, r.clr_fail, r.clr_ok, r.clr_go};
        default: next_r.rdata = 32'h0;
      endcase
    end
    if (acc && !pwrite && paddr == ADDR_CMD) begin
      next_r.rx_v = 1'b0;
    end
    if (acc && pwrite) begin
      unique case (paddr)
        ADDR_CON: begin
          if (!en_flag) begin
            next_r.master = pwdata[CON_MASTER_BIT];
            next_r.speed = pwdata[CON_SPEED_LSB+:2];
          end
        end
        ADDR_ENABLE: begin
          next_r.en = pwdata[EN_BIT];
          if (pwdata[ABORT_BIT] && r.master) begin
            next_r.abort = 1'b1;
          end
        end
        ADDR_SPIKE: begin
          if (!en_flag) begin
            // Zero would filter the same as one, and it is stored as one
            next_r.spk = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
          end
        end
        ADDR_RAW: begin
          if (pwdata[RAW_TXAB_BIT]) begin
            next_r.txab = 1'b0;
            next_r.ucause = 1'b0;
          end
        end
        ADDR_BCLR: begin
          if (pwdata[BCLR_GO_BIT] && r.st == ST_IDLE && !r.clr_go) begin
            next_r.clr_go = 1'b1;
            next_r.clr_ok = 1'b0;
            next_r.clr_fail = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Quarter-bit divider; rate follows the speed field
    if (tick) begin
      next_r.div = (r.speed == SPEED_STD) ? 6'(QTR_STD_CYC - 1)
                                          : 6'(QTR_FAST_CYC - 1);
    end else begin
      next_r.div = r.div - 6'h01;
    end
    if (tick) begin
      next_r.ph = r.ph + 2'h1;
      unique case (r.st)
        ST_IDLE: begin
          next_r.ph = 2'h0;
          next_r.scl_lo = 1'b0;
          next_r.sda_lo = 1'b0;
          if (r.clr_go) begin
            next_r.st = ST_CLR;
            next_r.bcnt = 4'h0;
          end else if (abort_ok) begin
            next_r.st = ST_STOP;
            next_r.aborting = 1'b1;
          end else if (r.en && r.master && wout.valid) begin
            next_r.st = ST_START;
          end
        end
        ST_START: begin
          if (r.ph == 2'h0) begin
            next_r.sda_lo = 1'b1;
          end else begin
            next_r.scl_lo = 1'b1;
            pop = 1'b1;
            next_r.cmd = wout.data;
            next_r.bcnt = 4'h7;
            next_r.st = ST_BIT;
            next_r.ph = 2'h0;
          end
        end
        ST_BIT: begin
          unique case (r.ph)
            2'h0: next_r.sda_lo = !r.cmd[CMD_RNW_BIT] && !r.cmd[r.bcnt[2:0]];
            2'h1: next_r.scl_lo = 1'b0;
            2'h2: next_r.sh = {r.sh[6:0], sda_f};
            2'h3: begin
              next_r.scl_lo = 1'b1;
              if (abort_ok) begin
                next_r.st = ST_STOP;
                next_r.aborting = 1'b1;
              end else if (r.bcnt == 4'h0) begin
                next_r.st = ST_ACK;
              end else begin
                next_r.bcnt = r.bcnt - 4'h1;
              end
            end
          endcase
        end
        ST_ACK: begin
          unique case (r.ph)
            // A read acknowledges unless it is the last of the transfer
            2'h0: next_r.sda_lo = r.cmd[CMD_RNW_BIT] && !r.cmd[CMD_STOP_BIT];
            2'h1: next_r.scl_lo = 1'b0;
            2'h2: begin
            end
            2'h3: begin
              next_r.scl_lo = 1'b1;
              if (r.cmd[CMD_RNW_BIT]) begin
                next_r.rx = r.sh;
                next_r.rx_v = 1'b1;
              end
              if (abort_ok) begin
                next_r.st = ST_STOP;
                next_r.aborting = 1'b1;
              end else if (r.cmd[CMD_STOP_BIT]) begin
                next_r.st = ST_STOP;
              end else if (wout.valid) begin
                pop = 1'b1;
                next_r.cmd = wout.data;
                next_r.bcnt = 4'h7;
                next_r.st = ST_BIT;
              end else begin
                next_r.st = ST_HOLD;
              end
            end
          endcase
        end
        ST_HOLD: begin
          // SCL stays low here even after disable
          next_r.ph = 2'h0;
          if (abort_ok) begin
            next_r.st = ST_STOP;
            next_r.aborting = 1'b1;
          end else if (wout.valid) begin
            pop = 1'b1;
            next_r.cmd = wout.data;
            next_r.bcnt = 4'h7;
            next_r.st = ST_BIT;
          end
        end
        ST_STOP: begin
          unique case (r.ph)
            2'h0: begin
              next_r.scl_lo = 1'b1;
              next_r.sda_lo = 1'b1;
            end
            2'h1: next_r.scl_lo = 1'b0;
            2'h2: next_r.sda_lo = 1'b0;
            2'h3: begin
              next_r.st = ST_IDLE;
              if (r.aborting) begin
                flush = 1'b1;
                next_r.aborting = 1'b0;
                next_r.abort = 1'b0;
                next_r.txab = 1'b1;
                next_r.ucause = 1'b1;
              end
              if (r.clr_go) begin
                next_r.clr_go = 1'b0;
                next_r.clr_ok = 1'b1;
              end
            end
          endcase
        end
        ST_CLR: begin
          unique case (r.ph)
            2'h0: begin
              next_r.scl_lo = 1'b1;
              next_r.sda_lo = 1'b0;
            end
            2'h1: next_r.scl_lo = 1'b0;
            2'h2: begin
              if (sda_f) begin
                next_r.st = ST_STOP;
                next_r.ph = 2'h0;
              end
            end
            2'h3: begin
              next_r.scl_lo = 1'b1;
              next_r.bcnt = r.bcnt + 4'h1;
              if (r.bcnt == CLR_LAST) begin
                // Nine pulses spent; only a reset frees the bus now
                next_r.st = ST_IDLE;
                next_r.scl_lo = 1'b0;
                next_r.clr_go = 1'b0;
                next_r.clr_fail = 1'b1;
              end
            end
          endcase
        end
        default: next_r.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st: ST_IDLE, master: CON_RST[CON_MASTER_BIT],
             speed: CON_RST[2:1], spk: SPK_RST, default: '0};
    end else begin
      r <= next_r;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  flag_idle_a: assert property ($fell(en_flag)
      |-> $past(r.st) inside {ST_IDLE, ST_STOP, ST_CLR})
    else $error("enabled flag dropped in mid transfer");
  idle_start_a: assert property (r.st == ST_IDLE && r.en && r.master
      && wout.valid && !r.clr_go && !abort_ok |-> ##[1:60] r.st == ST_START)
    else $error("queued command not started");
  stop_flag_a: assert property (r.st == ST_ACK && tick && r.ph == 2'h3
      && r.cmd[CMD_STOP_BIT] |=> r.st == ST_STOP)
    else $error("stop flag did not lead to STOP");
  hold_low_a: assert property (r.st == ST_HOLD |-> scl_oe)
    else $error("SCL released while holding");
  hold_stay_a: assert property (r.st == ST_HOLD && !wout.valid
      && !abort_ok |=> r.st == ST_HOLD)
    else $error("hold left without a command");
  abort_stop_a: assert property ($rose(r.abort) && r.st != ST_CLR
      |-> ##[1:260] r.st == ST_STOP)
    else $error("abort did not reach STOP");
  abort_event_a: assert property (r.st == ST_STOP && r.aborting && tick
      && r.ph == 2'h3 |=> r.txab && r.ucause && !wout.valid)
    else $error("abort end not reported");
  spk_min_a: assert property (r.spk != 8'h00)
    else $error("spike limit is zero");
  spk_lock_a: assert property (en_flag |=> $stable(r.spk))
    else $error("spike limit changed while enabled");
  flush_off_a: assert property (!en_flag |=> !wout.valid)
    else $error("commands kept while disabled");
  clr_bound_a: assert property (r.st == ST_CLR |-> r.bcnt <= CLR_LAST)
    else $error("more than nine recovery pulses");
  abort_cov: cover property (r.st == ST_STOP && r.aborting ##1 r.st == ST_IDLE);
  hold_cov: cover property (r.st == ST_ACK ##1 r.st == ST_HOLD);
  clr_ok_cov: cover property ($rose(r.clr_ok));
  clr_fail_cov: cover property ($rose(r.clr_fail));
endmodule // icm_master

//--- tb/icm_slave_model.sv
// Behavioural I2C target: takes written bytes, answers reads, can jam SDA
`timescale 1ns/1ps
module icm_slave_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Test controls
  input wire logic rd_mode,
  input wire logic [7:0] rd_byte,
  input wire logic jam,
  input wire logic [3:0] jam_n,
  // Target drive and capture
  output logic sda_rel,
  output logic [7:0] got_byte,
  output logic [7:0] got_n
);
  int bitc = 0;
  int stk = 0;
  logic drv = 1'b1;
  logic [7:0] sh = 8'h00;
  initial got_n = 8'h00;
  // Jam wins over everything, as a stuck target would
  assign sda_rel = drv && (stk == 0);
  always @(negedge sda) if (scl) bitc = 0;
  always @(posedge sda) if (scl) bitc = 0;
  always @(posedge jam) stk = int'(jam_n);
  always @(posedge scl) begin
    if (stk != 0) stk = stk - 1;
    if (bitc < 8) sh = {sh[6:0], sda};
    bitc = bitc + 1;
  end
  // Data only changes while SCL is low
  always @(negedge scl) begin
    drv = 1'b1;
    if (bitc == 8 && !rd_mode) begin
      drv = 1'b0;
      got_byte = sh;
      got_n = got_n + 8'h01;
    end else if (bitc < 8 && rd_mode) begin
      drv = rd_byte[7 - bitc];
    end
    if (bitc >= 9) bitc = 0;
  end
endmodule // icm_slave_model

//--- tb/test_i2c_master_cmd_abort_spike_busclear.sv
// Self-checking bench for the I2C master command engine
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_i2c_master_cmd_abort_spike_busclear;
  import icm_pkg::*;
  logic mclk, reset_n, psel, penable, pwrite, scl_oe, sda_oe;
  logic pready, pslverr, rd_mode, jam, sda_rel, pe;
  logic [7:0] paddr, rd_byte, got_byte, got_n, d1, d2;
  logic [3:0] jam_n;
  logic [31:0] pwdata, prdata, r;
  logic [32:0] rq[$];
  logic [7:0] sq[$];
  int error_cnt = 0;
  int cmp_count = 0;
  // Open-drain wires with pull-ups
  wire scl = !scl_oe;
  wire sda = !sda_oe && sda_rel;
  icm_master icm_master_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
  icm_slave_model icm_slave_model_i (.scl(scl), .sda(sda),
    .rd_mode(rd_mode), .rd_byte(rd_byte), .jam(jam), .jam_n(jam_n),
    .sda_rel(sda_rel), .got_byte(got_byte), .got_n(got_n));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge mclk);
    penable = 1'b1;
    while (pready !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 500) begin
      error_cnt++;
      print_verdict();
    end
    @(posedge mclk);
    r = prdata;
    pe = pslverr;
    @(negedge mclk);
    psel = 1'b0;
    penable = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back({1'b1, e});
    apb(1'b0, a, 32'h0);
  endtask
  // Poll until a status bit drops, with a bounded count of polls
  task automatic wait_clr(input logic [7:0] a, input int b, input int gap);
    int c;
    c = 0;
    repeat (30) @(negedge mclk);
    rq.push_back(33'h0);
    apb(1'b0, a, 32'h0);
    while (r[b] !== 1'b0 && c < 40) begin
      repeat (gap) @(negedge mclk);
      rq.push_back(33'h0);
      apb(1'b0, a, 32'h0);
      c++;
    end
    if (r[b] !== 1'b0) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic poll_off();
    wait_clr(ADDR_ESTATE, EN_BIT, 40 * QTR_FAST_CYC);
    `CHK(r[0], 1'b0)
  endtask
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin : apb_mon
    logic [32:0] e;
    if (psel && penable && pready && !pwrite) begin
      e = rq.pop_front();
      if (e[32]) `CHK(prdata, e[31:0])
    end
  end
  always @(got_n) begin : byte_mon
    logic [7:0] e;
    e = sq.size() ? sq.pop_front() : ~got_byte;
    if (got_n != 8'h00) `CHK(got_byte, e)
  end
  // Whole run needs under 10000 cycles; give up after 40000
  initial begin
    #2000000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd_mode = 1'b0;
    rd_byte = 8'hFF;
    jam = 1'b0;
    jam_n = 4'h0;
    void'($urandom(51));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    rd(ADDR_CON, {29'h0, CON_RST});
    `CHK(pe, 1'b0)
    rd(ADDR_SPIKE, {24'h0, SPK_RST});
    rd(ADDR_ESTATE, 32'h0);
    rd(8'h20, 32'h0);
    `CHK(pe, 1'b1)
    wr(ADDR_SPIKE, 32'h0);
    rd(ADDR_SPIKE, 32'h1);
    wr(ADDR_SPIKE, 32'h3);
    wr(ADDR_CON, 32'h5);
    // Command queued while disabled must never reach the wire
    wr(ADDR_CMD, {24'h0, ~d1});
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_SPIKE, 32'h7);
    wr(ADDR_CON, 32'h3);
    rd(ADDR_SPIKE, 32'h3);
    rd(ADDR_CON, 32'h5);
    sq.push_back(d1);
    sq.push_back(d2);
    wr(ADDR_CMD, {22'h0, 2'b00, d1});
    wr(ADDR_CMD, {22'h0, 2'b10, d2});
    repeat (100) @(negedge mclk);
    wr(ADDR_ENABLE, 32'h0);
    poll_off();
    `CHK(got_n, 8'h02)
    `CHK(scl_oe, 1'b0)
    rd_mode = 1'b1;
    rd_byte = d1;
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_CMD, 32'h300);
    // Received byte is dropped once disabled, so read it while enabled
    repeat (600) @(negedge mclk);
    rd(ADDR_CMD, {23'h0, 1'b1, d1});
    rd(ADDR_CMD, {24'h0, d1});
    wr(ADDR_ENABLE, 32'h0);
    poll_off();
    rd_mode = 1'b0;
    sq.push_back(d2);
    wr(ADDR_ENABLE, 32'h1);
    wr(ADDR_CMD, {24'h0, d2});
    repeat (1000) @(negedge mclk);
    `CHK(scl_oe, 1'b1)
    wr(ADDR_ENABLE, 32'h0);
    repeat (200) @(negedge mclk);
    rd(ADDR_ESTATE, 32'h1);
    `CHK(scl_oe, 1'b1)
    wr(ADDR_ENABLE, 32'h2);
    poll_off();
    `CHK(scl_oe, 1'b0)
    rd(ADDR_RAW, 32'h1 << RAW_TXAB_BIT);
    rd(ADDR_ABRT, 32'h1);
    wr(ADDR_RAW, 32'h1 << RAW_TXAB_BIT);
    rd(ADDR_ABRT, 32'h0);
    // Abort must do nothing once master operation is off
    wr(ADDR_CON, 32'h4);
    wr(ADDR_ENABLE, 32'h2);
    repeat (300) @(negedge mclk);
    rd(ADDR_RAW, 32'h0);
    wr(ADDR_CON, 32'h5);
    rd_mode = 1'b1;
    rd_byte = 8'hFF;
    jam_n = 4'd3;
    jam = 1'b1;
    wr(ADDR_BCLR, 32'h1);
    wait_clr(ADDR_BCLR, BCLR_GO_BIT, 100);
    `CHK(r[2:1], 2'b01)
    jam = 1'b0;
    jam_n = 4'd12;
    @(negedge mclk);
    jam = 1'b1;
    wr(ADDR_BCLR, 32'h1);
    wait_clr(ADDR_BCLR, BCLR_GO_BIT, 100);
    `CHK(r[BCLR_FAIL_BIT], 1'b1)
    print_verdict();
  end
endmodule // test_i2c_master_cmd_abort_spike_busclear
